// file: bcs_bank_state.sv
`timescale 1ns/100ps
`include "bcs_defines.svh"
// Behaviour
// - read auto precharge busy until row precharge
// - write auto precharge busy until row precharge
// - per-bank refresh busy until refresh time
// - all-bank refresh busy, then all idle
// - idle or resetting mode read, then idle
// - active-bank mode read returns bank active
// - mode write busy, then all banks idle
// - precharge all busy, then all idle
// - precharge to idle bank still waits
// - other banks follow their own state
// - mode read from busy bank moves state
// - other banks take activate read write precharge
// - reset write from power-on starts resetting
// - resetting accepts mode read, resetting-read state
// - commands taken only with clock enable high at two edges
// - reset is a mode write to reset address
module bcs_bank_state
   import bcs_pkg::*;
#(
   parameter int NBANK = 8,
   parameter int BLEN  = 4   // burst length in clock cycles
)(
   input  wire logic                     CORE_CLK,
   input  wire logic                     SYS_RST,
   input  wire logic                     CKE,
   input  wire logic                     CMD_VALID,
   input  wire logic [3:0]               CMD,
   input  wire logic [$clog2(NBANK)-1:0] CMD_BANK,
   input  wire logic                     CMD_AP,
   output logic [4*NBANK-1:0]            BANK_STATE,
   output logic [3:0]                    DEV_STATE,
   output logic                          ALL_IDLE,
   output logic                          CMD_ILLEGAL
);
   localparam int BW = $clog2(NBANK);
   localparam logic [`BCS_TW-1:0] T_RP    = `BCS_TW'(`BCS_TRP_CYC);
   localparam logic [`BCS_TW-1:0] T_RCD   = `BCS_TW'(`BCS_TRCD_CYC);
   localparam logic [`BCS_TW-1:0] T_RFCPB = `BCS_TW'(`BCS_TRFCPB_CYC);
   localparam logic [`BCS_TW-1:0] T_RFCAB = `BCS_TW'(`BCS_TRFCAB_CYC);
   localparam logic [`BCS_TW-1:0] T_MRR   = `BCS_TW'(`BCS_TMRR_CYC);
   localparam logic [`BCS_TW-1:0] T_MRW   = `BCS_TW'(`BCS_TMRW_CYC);
   localparam logic [`BCS_TW-1:0] T_XSR   = `BCS_TW'(`BCS_TXSR_CYC);
   localparam logic [`BCS_TW-1:0] T_BL    = `BCS_TW'(BLEN);

   // clock enable history, same domain as the command source
   logic                cke_prev_r;     // cke at previous edge
   logic                cke_ok;         // both edges high
   bcs_dev_e            dev_r;          // device-wide state
   bcs_dev_e            dev_nxt;
   logic [`BCS_TW-1:0]  dev_tmr_r;      // device timer
   logic [`BCS_TW-1:0]  dev_tmr_nxt;
   logic                dev_exp;        // device timer done
   bcs_cmd_e            cmd;            // typed command
   logic                take;           // command registered this edge
   logic                all_idle;       // every bank idle
   logic                any_act;        // some bank has open row
   logic                rd_burst;       // a read burst still running
   logic                wr_burst;       // a write burst still running
   logic                dev_free;       // device in normal running state
   logic [NBANK-1:0]    bank_idle;
   logic [NBANK-1:0]    bank_rd;
   logic [NBANK-1:0]    bank_wr;
   logic [NBANK-1:0]    bank_open;
   logic [NBANK-1:0]    bank_bad;       // per-bank illegal flag
   logic                dev_bad;        // device-level illegal flag
   logic [`BCS_TW-1:0]  burst_r;        // remaining burst cycles
   logic                burst_rd_r;     // burst kind is read

   assign cmd      = bcs_cmd_e'(CMD);
   assign cke_ok   = CKE & cke_prev_r;
   assign take     = CMD_VALID & cke_ok & (cmd != BCS_C_NOP);
   assign dev_exp  = (dev_tmr_r <= `BCS_TW'(1));
   assign all_idle = &bank_idle;
   assign any_act  = |bank_open;
   assign rd_burst = (burst_r != '0) & burst_rd_r;
   assign wr_burst = (burst_r != '0) & ~burst_rd_r;
   assign dev_free = (dev_r == BCS_D_RUN);

   // clock enable history
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
      if (SYS_RST)
         cke_prev_r <= 1'b0;
      else
         cke_prev_r <= CKE;

   // burst tracker; for read/write turnaround and refresh checks
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
      if (SYS_RST)
      begin
         burst_r    <= '0;
         burst_rd_r <= 1'b0;
      end
      else if (take && dev_free && (cmd == BCS_C_RD || cmd == BCS_C_WR))
      begin
         burst_r    <= T_BL;
         burst_rd_r <= (cmd == BCS_C_RD);
      end
      else if (burst_r != '0)
         burst_r <= burst_r - `BCS_TW'(1);

   // device-wide next state
   always_comb
   begin
      dev_nxt     = dev_r;
      dev_tmr_nxt = (dev_tmr_r != '0) ? dev_tmr_r - `BCS_TW'(1) : '0;
      dev_bad     = 1'b0;
      unique case (dev_r)
         BCS_D_PWRON:
            if (take)
            begin
               if (cmd == BCS_C_MRW_RESET)
                  dev_nxt = BCS_D_RESETTING;
               else
                  dev_bad = 1'b1;
            end
         BCS_D_RESETTING:
            if (take)
            begin
               if (cmd == BCS_C_MRR)
               begin
                  dev_nxt     = BCS_D_RMRR;
                  dev_tmr_nxt = T_MRR;
               end
               else if (cmd == BCS_C_MRW || cmd == BCS_C_MRW_RESET)
               begin
                  dev_nxt     = BCS_D_MRW;
                  dev_tmr_nxt = T_MRW;
               end
               else
                  dev_bad = 1'b1;
            end
         BCS_D_RUN:
            if (take)
            begin
               unique case (cmd)
                  BCS_C_REFAB:
                  begin
                     dev_bad     = ~all_idle | rd_burst | wr_burst;
                     dev_nxt     = BCS_D_REFAB;
                     dev_tmr_nxt = T_RFCAB;
                  end
                  BCS_C_MRW, BCS_C_MRW_RESET:
                  begin
                     dev_bad     = ~all_idle;
                     dev_nxt     = BCS_D_MRW;
                     dev_tmr_nxt = T_MRW;
                  end
                  BCS_C_PREA:
                  begin
                     dev_nxt     = BCS_D_PREA;
                     dev_tmr_nxt = T_RP;
                  end
                  BCS_C_MRR:
                     if (!any_act)
                     begin
                        dev_nxt     = BCS_D_IMRR;
                        dev_tmr_nxt = T_MRR;
                     end
                  BCS_C_SRE:
                  begin
                     dev_bad     = ~all_idle;
                     dev_nxt     = BCS_D_EXIT;
                     dev_tmr_nxt = T_XSR;
                  end
                  default: ;
               endcase
            end
         BCS_D_REFAB, BCS_D_IMRR, BCS_D_RMRR, BCS_D_MRW, BCS_D_PREA, BCS_D_EXIT:
         begin
            dev_bad = take;
            if (dev_exp)
               dev_nxt = BCS_D_RUN;
         end
         default:
            dev_nxt = BCS_D_PWRON;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST)
      if (SYS_RST)
      begin
         dev_r     <= BCS_D_PWRON;
         dev_tmr_r <= '0;
      end
      else
      begin
         dev_r     <= dev_nxt;
         dev_tmr_r <= dev_tmr_nxt;
      end

   // one state machine per bank
   for (genvar b = 0; b < NBANK; b++)
   begin : g_bank
      bcs_bank_e           st_r;
      bcs_bank_e           st_nxt;
      logic [`BCS_TW-1:0]  tmr_r;
      logic [`BCS_TW-1:0]  tmr_nxt;
      logic                hit;      // command aimed at this bank
      logic                exp;
      logic                bad;
      assign hit = take & dev_free & (CMD_BANK == BW'(b));
      assign exp = (tmr_r <= `BCS_TW'(1));
      assign bank_idle[b] = (st_r == BCS_B_IDLE);
      assign bank_rd[b]   = (st_r == BCS_B_READ) | (st_r == BCS_B_READ_AP);
      assign bank_wr[b]   = (st_r == BCS_B_WRITE) | (st_r == BCS_B_WRITE_AP);
      assign bank_open[b] = (st_r != BCS_B_IDLE) & (st_r != BCS_B_REFPB);
      assign bank_bad[b]  = bad;

      always_comb
      begin
         st_nxt  = st_r;
         tmr_nxt = (tmr_r != '0) ? tmr_r - `BCS_TW'(1) : '0;
         bad     = 1'b0;
         // precharge all forces every bank to idle after tRP
         if (dev_r == BCS_D_PREA && dev_exp)
            st_nxt = BCS_B_IDLE;
         else if (hit && cmd == BCS_C_MRR && st_r != BCS_B_IDLE)
         begin
            st_nxt  = BCS_B_AMRR;
            tmr_nxt = T_MRR;
         end
         else if (hit)
         begin
            unique case (cmd)
               BCS_C_ACT:
               begin
                  bad     = ~bank_idle[b];
                  st_nxt  = BCS_B_ACTING;
                  tmr_nxt = T_RCD;
               end
               BCS_C_RD:
               begin
                  bad     = wr_burst | bank_idle[b];
                  st_nxt  = CMD_AP ? BCS_B_READ_AP : BCS_B_READ;
                  tmr_nxt = CMD_AP ? T_BL + T_RP : T_BL;
               end
               BCS_C_WR:
               begin
                  bad     = rd_burst | bank_idle[b];
                  st_nxt  = CMD_AP ? BCS_B_WRITE_AP : BCS_B_WRITE;
                  tmr_nxt = CMD_AP ? T_BL + T_RP : T_BL;
               end
               BCS_C_PRE:
               begin
                  st_nxt  = BCS_B_PRE;
                  tmr_nxt = T_RP;
               end
               BCS_C_REFPB:
               begin
                  bad     = ~bank_idle[b] | rd_burst | wr_burst;
                  st_nxt  = BCS_B_REFPB;
                  tmr_nxt = T_RFCPB;
               end
               default: ;
            endcase
            if (st_r == BCS_B_READ_AP || st_r == BCS_B_WRITE_AP || st_r == BCS_B_REFPB)
               bad = 1'b1;
         end
         else if (exp)
         begin
            unique case (st_r)
               BCS_B_ACTING, BCS_B_READ, BCS_B_WRITE, BCS_B_AMRR:
                  st_nxt = (tmr_r == '0 && st_r != BCS_B_AMRR) ? st_r : BCS_B_ACTIVE;
               BCS_B_READ_AP, BCS_B_WRITE_AP, BCS_B_PRE, BCS_B_REFPB:
                  st_nxt = BCS_B_IDLE;
               default: ;
            endcase
         end
      end

      always_ff @(posedge CORE_CLK or posedge SYS_RST)
         if (SYS_RST)
         begin
            st_r  <= BCS_B_IDLE;
            tmr_r <= '0;
         end
         else
         begin
            st_r  <= st_nxt;
            tmr_r <= tmr_nxt;
         end

      // read auto precharge ends in idle once the bank's own row timer is done
      AST_AP_IDLE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
         (st_r == BCS_B_READ_AP && exp && !hit && !(dev_r == BCS_D_PREA)) |=> (st_r == BCS_B_IDLE))
         else $error("read auto precharge did not end in idle");
      AST_REFPB: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
         (hit && cmd == BCS_C_REFPB && dev_r == BCS_D_RUN) |=> (st_r == BCS_B_REFPB))
         else $error("per-bank refresh not entered");
      AST_PRE_IDLE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
         (hit && cmd == BCS_C_PRE && bank_idle[b]) |=> (st_r == BCS_B_PRE))
         else $error("precharge to idle bank skipped tRP");
   end

   // outputs registered
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
      if (SYS_RST)
      begin
         BANK_STATE  <= '0;
         DEV_STATE   <= '0;
         ALL_IDLE    <= 1'b0;
         CMD_ILLEGAL <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NBANK; i++)
            BANK_STATE[4*i +: 4] <= {bank_rd[i] | bank_wr[i], bank_open[i], bank_wr[i], bank_idle[i]};
         DEV_STATE   <= dev_nxt;
         ALL_IDLE    <= all_idle & dev_free;
         CMD_ILLEGAL <= dev_bad | (|bank_bad);
      end

   AST_RESET_SEQ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (dev_r == BCS_D_PWRON && take && cmd == BCS_C_MRW_RESET) |=> (dev_r == BCS_D_RESETTING))
      else $error("reset write did not start resetting");
   AST_RMRR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (dev_r == BCS_D_RESETTING && take && cmd == BCS_C_MRR) |=> (dev_r == BCS_D_RMRR))
      else $error("resetting mode read not entered");
   AST_REFAB: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (dev_r == BCS_D_RUN && take && cmd == BCS_C_REFAB) |=> (dev_r == BCS_D_REFAB) ##[1:40] (dev_r == BCS_D_RUN))
      else $error("all-bank refresh did not end in time");
   AST_MRW: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (dev_r == BCS_D_RUN && take && cmd == BCS_C_MRW) |=> (dev_r == BCS_D_MRW) ##[1:20] (dev_r == BCS_D_RUN))
      else $error("mode write did not end in time");
   AST_CKE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (!cke_prev_r && dev_r == BCS_D_PWRON) |=> (dev_r != BCS_D_RESETTING))
      else $error("transition taken with clock enable low");
endmodule // bcs_bank_state

// file: bcs_ctrl_model.sv
`timescale 1ns/100ps
// memory controller stand-in; drives its lines just after the rising edge
module bcs_ctrl_model
   import bcs_pkg::*;
#(
   parameter int TRRD = 2   // activate spacing in cycles, plain default
)(
   input  wire logic        CORE_CLK,
   input  wire logic        ALL_IDLE,
   input  wire logic [31:0] BANK_STATE,
   output logic             CKE,
   output logic             CMD_VALID,
   output logic [3:0]       CMD,
   output logic [2:0]       CMD_BANK,
   output logic             CMD_AP
);
   int   act_age = 99;   // edges since the last activate
   logic any_burst;      // some bank still moves data
   assign any_burst = |(BANK_STATE & 32'h88888888);
   initial
   begin
      CKE = 1'b1;
      CMD_VALID = 1'b0;
      CMD = BCS_C_NOP;
      CMD_BANK = 3'h0;
      CMD_AP = 1'b0;
   end
   // age of the last activate, for bank-to-bank spacing
   always @(posedge CORE_CLK)
      act_age <= (CMD_VALID && CMD == BCS_C_ACT) ? 0 : act_age + 1;
   // one command held over one sampling edge; raw skips the guards
   task automatic send(input bcs_cmd_e c, input logic [2:0] b, input logic ap, input bit raw);
      int n;
      n = 0;
      // guards are slow on purpose: a real controller waits the same way
      while (!raw && n < 64 && ((c inside {BCS_C_REFAB, BCS_C_MRW} && ALL_IDLE !== 1'b1)
             || (c inside {BCS_C_RD, BCS_C_WR} && any_burst !== 1'b0)
             || (c inside {BCS_C_ACT, BCS_C_REFPB} && BANK_STATE[4*b] !== 1'b1)
             || (c inside {BCS_C_PRE, BCS_C_MRR} && BANK_STATE[4*b+3] !== 1'b0)
             || (c == BCS_C_ACT && act_age < TRRD)))
      begin
         @(posedge CORE_CLK);
         n++;
      end
      @(posedge CORE_CLK);
      #1;
      CMD_VALID = 1'b1;
      CMD = c;
      CMD_BANK = b;
      CMD_AP = ap;
      @(posedge CORE_CLK);
      #1;
      // back to no-operation; released lines carry junk, not the old value
      CMD_VALID = 1'b0;
      CMD = BCS_C_NOP;
      CMD_BANK = ~b;
      CMD_AP = ~ap;
   endtask
   // clock enable change, away from the sampling edge
   task automatic set_cke(input logic v);
      @(posedge CORE_CLK);
      #1;
      CKE = v;
   endtask
endmodule // bcs_ctrl_model

// file: bcs_defines.svh
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
// clock period in ps (125 MHz)
`define BCS_CLK_PS        8000
// timing figures in ns, defaults of plain value
`define BCS_TRP_NS        18
`define BCS_TRCD_NS       18
`define BCS_TRFCPB_NS     90
`define BCS_TRFCAB_NS     210
`define BCS_TMRR_NS       32
`define BCS_TMRW_NS       80
`define BCS_TXP_NS        8
`define BCS_TXSR_NS       220
// least times round up to whole cycles
`define BCS_CYC(ns)       (((ns) * 1000 + `BCS_CLK_PS - 1) / `BCS_CLK_PS)
`define BCS_TRP_CYC       `BCS_CYC(`BCS_TRP_NS)
`define BCS_TRCD_CYC      `BCS_CYC(`BCS_TRCD_NS)
`define BCS_TRFCPB_CYC    `BCS_CYC(`BCS_TRFCPB_NS)
`define BCS_TRFCAB_CYC    `BCS_CYC(`BCS_TRFCAB_NS)
`define BCS_TMRR_CYC      `BCS_CYC(`BCS_TMRR_NS)
`define BCS_TMRW_CYC      `BCS_CYC(`BCS_TMRW_NS)
`define BCS_TXP_CYC       `BCS_CYC(`BCS_TXP_NS)
`define BCS_TXSR_CYC      `BCS_CYC(`BCS_TXSR_NS)
// timer width
`define BCS_TW            8
`endif

// file: bcs_pkg.sv
package bcs_pkg;
   // decoded command presented by the front end
   typedef enum logic [3:0] {
      BCS_C_NOP, BCS_C_ACT, BCS_C_RD, BCS_C_WR, BCS_C_PRE, BCS_C_PREA,
      BCS_C_REFPB, BCS_C_REFAB, BCS_C_MRR, BCS_C_MRW, BCS_C_MRW_RESET,
      BCS_C_SRE, BCS_C_PDX
   } bcs_cmd_e;
   // per-bank state
   typedef enum logic [3:0] {
      BCS_B_IDLE, BCS_B_ACTING, BCS_B_ACTIVE, BCS_B_READ, BCS_B_WRITE,
      BCS_B_READ_AP, BCS_B_WRITE_AP, BCS_B_PRE, BCS_B_REFPB, BCS_B_AMRR
   } bcs_bank_e;
   // device-wide state
   typedef enum logic [3:0] {
      BCS_D_PWRON, BCS_D_RESETTING, BCS_D_RUN, BCS_D_REFAB, BCS_D_IMRR,
      BCS_D_RMRR, BCS_D_MRW, BCS_D_PREA, BCS_D_EXIT
   } bcs_dev_e;
endpackage

// file: tb_top.sv
`timescale 1ns/100ps
`include "bcs_defines.svh"
// self-checking bench for the bank command state block
module tb_top
   import bcs_pkg::*;
;
   typedef struct {
      bcs_cmd_e c;   // command
      logic [2:0] b; // bank
      bcs_dev_e d;   // device state while busy
      int t;         // busy span in cycles
   } bcs_row_s;
   localparam int TAP = 4 + `BCS_TRP_CYC; // burst plus row precharge
   logic        CORE_CLK = 1'b0;
   logic        SYS_RST  = 1'b1;
   logic        CKE, CMD_VALID, CMD_AP, ALL_IDLE, CMD_ILLEGAL;
   logic [3:0]  CMD, DEV_STATE;
   logic [2:0]  CMD_BANK;
   logic [31:0] BANK_STATE;
   logic [32:0] watch;           // all-idle flag above the bank bits
   logic        ill_seen = 1'b0; // sticky copy of the illegal pulse
   int          miscompares = 0;
   int          checks = 0;
   int          n;
   bcs_row_s    rows [6] = '{
      '{BCS_C_REFAB, 3'h0, BCS_D_REFAB, `BCS_TRFCAB_CYC},
      '{BCS_C_PREA, 3'h0, BCS_D_PREA, `BCS_TRP_CYC},
      '{BCS_C_MRR, 3'h0, BCS_D_IMRR, `BCS_TMRR_CYC},
      '{BCS_C_MRW, 3'h0, BCS_D_MRW, `BCS_TMRW_CYC},
      '{BCS_C_REFPB, 3'h1, BCS_D_RUN, `BCS_TRFCPB_CYC},
      '{BCS_C_PRE, 3'h3, BCS_D_RUN, `BCS_TRP_CYC}};
   assign watch = {ALL_IDLE, BANK_STATE};
   always #4 CORE_CLK = ~CORE_CLK;
   // a one-cycle pulse is easy to miss, so keep it
   always @(posedge CORE_CLK)
      if (CMD_ILLEGAL === 1'b1)
         ill_seen <= 1'b1;
   bcs_bank_state bcs_bank_state_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CKE(CKE),
      .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_BANK(CMD_BANK), .CMD_AP(CMD_AP),
      .BANK_STATE(BANK_STATE), .DEV_STATE(DEV_STATE), .ALL_IDLE(ALL_IDLE), .CMD_ILLEGAL(CMD_ILLEGAL));
   bcs_ctrl_model bcs_ctrl_model_i (.CORE_CLK(CORE_CLK), .ALL_IDLE(ALL_IDLE), .BANK_STATE(BANK_STATE),
      .CKE(CKE), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_BANK(CMD_BANK), .CMD_AP(CMD_AP));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic step();
      @(posedge CORE_CLK);
      #1;
   endtask
   // command, then one edge so the registered answer has landed
   task automatic go(input bcs_cmd_e c, input logic [2:0] b, input logic ap, input bit raw);
      bcs_ctrl_model_i.send(c, b, ap, raw);
      step();
   endtask
   // edges until the watched bit is high, bounded
   task automatic settle(input int idx, output int k);
      k = 0;
      while (watch[idx] !== 1'b1 && k < 80)
      begin
         step();
         k++;
      end
      // a wait that runs out is a failure of its own
      if (watch[idx] !== 1'b1)
         chk("settle limit", 32'h1, 32'(watch[idx]));
   endtask
   // busy span measured from the taking edge, one cycle of slack below, two above
   task automatic span(input int k, input int t);
      chk("busy span", 32'h1, 32'(k >= t - 1 && k <= t + 2));
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      miscompares++;
      results();
   end
   // main sequence
   initial
   begin
      repeat (6) @(posedge CORE_CLK);
      chk("outputs in reset", 32'h0, 32'({DEV_STATE, ALL_IDLE, CMD_ILLEGAL}));
      #1 SYS_RST = 1'b0;
      step();
      go(BCS_C_MRW_RESET, 3'h0, 1'b0, 1'b1);
      chk("resetting", 32'(BCS_D_RESETTING), 32'(DEV_STATE));
      go(BCS_C_MRR, 3'h0, 1'b0, 1'b1);
      chk("resetting read", 32'(BCS_D_RMRR), 32'(DEV_STATE));
      settle(32, n);
      span(n + 1, `BCS_TMRR_CYC);
      // ordinary busy states entered from all banks idle
      foreach (rows[i])
      begin
         go(rows[i].c, rows[i].b, 1'b0, 1'b0);
         chk("busy state", 32'(rows[i].d), 32'(DEV_STATE));
         chk("not idle", 32'h0, 32'(ALL_IDLE));
         settle(32, n);
         span(n + 1, rows[i].t);
      end
      chk("no illegal flag", 32'h0, 32'(ill_seen));
      // activate leaves the other banks alone; the open bit cannot tell activating from active
      go(BCS_C_ACT, 3'h2, 1'b0, 1'b0);
      chk("idle bits 2 and 0", 32'h1, 32'({BANK_STATE[8], BANK_STATE[0]}));
      repeat (`BCS_TRCD_CYC - 2) step();
      chk("bank 2 activating", 32'(BCS_B_ACTING), 32'(bcs_bank_state_i.g_bank[2].st_r));
      step();
      chk("bank 2 active", 32'(BCS_B_ACTIVE), 32'(bcs_bank_state_i.g_bank[2].st_r));
      go(BCS_C_RD, 3'h2, 1'b1, 1'b0);
      chk("bank 2 read burst", 32'h2, 32'({BANK_STATE[11], BANK_STATE[9]}));
      settle(8, n);
      span(n + 1, TAP);
      // activate to another bank while one writes with auto precharge
      go(BCS_C_ACT, 3'h5, 1'b0, 1'b0);
      repeat (`BCS_TRCD_CYC) step();
      bcs_ctrl_model_i.send(BCS_C_WR, 3'h5, 1'b1, 1'b0);
      go(BCS_C_ACT, 3'h6, 1'b0, 1'b0);
      chk("bank 6 left idle", 32'h0, 32'(BANK_STATE[24]));
      repeat (`BCS_TRCD_CYC) step();
      go(BCS_C_WR, 3'h6, 1'b1, 1'b0);
      chk("bank 6 write burst", 32'h3, 32'({BANK_STATE[27], BANK_STATE[25]}));
      settle(24, n);
      span(n + 1, TAP);
      settle(20, n);
      chk("bank 5 idle", 32'h1, 32'(BANK_STATE[20]));
      // mode read with a bank open returns it to active
      go(BCS_C_ACT, 3'h7, 1'b0, 1'b0);
      repeat (`BCS_TRCD_CYC) step();
      go(BCS_C_MRR, 3'h7, 1'b0, 1'b0);
      chk("bank 7 mode read", 32'(BCS_B_AMRR), 32'(bcs_bank_state_i.g_bank[7].st_r));
      repeat (`BCS_TMRR_CYC) step();
      chk("bank 7 open", 32'h1, 32'(BANK_STATE[30]));
      chk("bank 7 active again", 32'(BCS_B_ACTIVE), 32'(bcs_bank_state_i.g_bank[7].st_r));
      chk("running", 32'(BCS_D_RUN), 32'(DEV_STATE));
      go(BCS_C_PRE, 3'h7, 1'b0, 1'b0);
      settle(32, n);
      // with clock enable low a command is not taken
      bcs_ctrl_model_i.set_cke(1'b0);
      go(BCS_C_REFAB, 3'h0, 1'b0, 1'b1);
      step();
      chk("refresh ignored", 32'h0, 32'(DEV_STATE == BCS_D_REFAB));
      bcs_ctrl_model_i.set_cke(1'b1);
      settle(32, n);
      // read to an idle bank is flagged
      go(BCS_C_RD, 3'h0, 1'b0, 1'b1);
      step();
      chk("illegal flag", 32'h1, 32'(ill_seen));
      go(BCS_C_PRE, 3'h0, 1'b0, 1'b1);
      settle(32, n);
      // second reset in mid-run
      SYS_RST = 1'b1;
      step();
      chk("outputs in reset", 32'h0, 32'({DEV_STATE, ALL_IDLE, CMD_ILLEGAL}));
      chk("bank state in reset", 32'h0, BANK_STATE);
      SYS_RST = 1'b0;
      step();
      step();
      go(BCS_C_MRW_RESET, 3'h0, 1'b0, 1'b1);
      chk("resetting again", 32'(BCS_D_RESETTING), 32'(DEV_STATE));
      results();
   end
endmodule // tb_top
